// File: fpe_map.vh
`ifndef FPE_MAP_VH
`define FPE_MAP_VH
// opcodes
`define FPE_OP_PROG        8'h02
`define FPE_OP_QPROG       8'h32
`define FPE_OP_SECT_ERASE  8'h20
`define FPE_OP_BLK32_ERASE 8'h52
`define FPE_OP_BLK64_ERASE 8'hD8
// frame geometry in bits
`define FPE_OPCODE_BITS    8'h08
`define FPE_ADDR_END_BITS  8'h20
// erased byte value
`define FPE_ERASED_BYTE    8'hFF
// operation kinds reported to the array
`define FPE_KIND_PROG      3'h1
`define FPE_KIND_SECT      3'h2
`define FPE_KIND_BLK32     3'h3
`define FPE_KIND_BLK64     3'h4
// cycle times in microseconds and clock rate in MHz
`define FPE_CLK_MHZ        40
`define FPE_PROG_TIME_US   700
`define FPE_SECT_TIME_US   45000
`define FPE_BLK32_TIME_US  120000
`define FPE_BLK64_TIME_US  150000
`endif

// File: fpe_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "fpe_map.vh"
module fpe_sequencer #(
    parameter PROG_CYCLES  = (`FPE_PROG_TIME_US * `FPE_CLK_MHZ),
    parameter SECT_CYCLES  = (`FPE_SECT_TIME_US * `FPE_CLK_MHZ),
    parameter BLK32_CYCLES = (`FPE_BLK32_TIME_US * `FPE_CLK_MHZ),
    parameter BLK64_CYCLES = (`FPE_BLK64_TIME_US * `FPE_CLK_MHZ)
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        arst_n_i,
    // serial link, sampled on this clock: one bit or nibble strobe per shift
    input  wire        cs_n_i,
    input  wire        shift_i,
    input  wire        serial_data_in_i,
    input  wire        quad_line0_i,
    input  wire        quad_line1_i,
    input  wire        quad_line2_i,
    input  wire        quad_line3_i,
    // configuration and status bits
    input  wire        four_line_command_mode_i,
    input  wire        quad_enable_bit_i,
    input  wire        write_enable_latch_i,
    input  wire        protect_complement_bit_i,
    input  wire        protect_granularity_bit_i,
    input  wire        protect_top_bottom_bit_i,
    input  wire        protect_range_bit2_i,
    input  wire        protect_range_bit1_i,
    input  wire        protect_range_bit0_i,
    input  wire        status_read_i,
    output wire        busy_o,
    output reg         clear_write_enable_o,
    output reg  [15:0] status_data_o,
    // array write port, data side through a two-entry buffer
    output wire        wr_valid_o,
    input  wire        wr_ready_i,
    output wire [23:0] wr_addr_o,
    output wire [7:0]  wr_data_o,
    output reg         op_start_o,
    output reg  [2:0]  op_kind_o,
    output reg  [23:0] op_addr_o,
    output reg         op_done_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_BUSY = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg        rst_m;
    reg        rst_s;
    reg [1:0]  state;
    reg [7:0]  opcode;
    reg [23:0] addr;
    reg [7:0]  shreg;
    reg [7:0]  bitcnt;
    reg        quad;
    reg        rejected;
    reg [31:0] timer;
    reg        byte_taken;
    reg [7:0]  page_ofs;
    reg [8:0]  byte_count;
    // two-entry buffer storage
    reg [31:0] buf_mem [0:1];
    reg        buf_wp;
    reg        buf_rp;
    reg [1:0]  buf_cnt;

    wire       rst_n = rst_s;
    wire [3:0] nib = {quad_line3_i, quad_line2_i, quad_line1_i, quad_line0_i};
    wire       is_prog = (opcode == `FPE_OP_PROG) || (opcode == `FPE_OP_QPROG);
    wire       buf_full = (buf_cnt == 2'h2);
    // a whole byte waits at a boundary; taken once, and held back while the buffer is full
    wire       take_byte = (state == ST_IDLE) && !cs_n_i && !rejected && (opcode != 8'h00) && !shift_i
                           && (bitcnt[2:0] == 3'h0) && (bitcnt > 8'h88) && !byte_taken && !buf_full;

    // protected-range check; block granule 64 KB, sector granule 4 KB
    function prot_hit;
        input [23:0] a;
        input [2:0]  bp;
        input        sec;
        input        tb;
        input        cmp;
        reg   [5:0]  blk;
        reg          hit;
        begin
            blk = a[21:16];
            hit = 1'b0;
            if (bp == 3'h7)
                hit = 1'b1;
            else if (bp != 3'h0)
            begin
                if (sec)
                    hit = tb ? ({1'b0, a[21:12]} < (11'h001 << bp[1:0]))
                             : ({1'b0, a[21:12]} >= (11'h400 - (11'h001 << bp[1:0])));
                else
                    hit = tb ? ({1'b0, blk} < (7'h01 << bp))
                             : ({1'b0, blk} >= (7'h40 - (7'h01 << bp)));
            end
            prot_hit = cmp ? ~hit : hit;
        end
    endfunction

    // reset release through two flops
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    assign busy_o = (state != ST_IDLE);

    // status answered in every state, even mid-cycle
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            status_data_o <= 16'h0000;
        else if (status_read_i)
            status_data_o <= {6'h00, quad_enable_bit_i, 7'h00, write_enable_latch_i, busy_o};
    end

    // buffer outputs
    assign wr_valid_o = (buf_cnt != 2'h0);
    assign wr_addr_o  = buf_mem[buf_rp][31:8];
    assign wr_data_o  = buf_mem[buf_rp][7:0];

    // frame shifting, command decode and self-timed cycle
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE; opcode <= 8'h00; addr <= 24'h000000;
            shreg <= 8'h00; bitcnt <= 8'h00; quad <= 1'b0; rejected <= 1'b0;
            timer <= 32'h00000000; byte_taken <= 1'b0; page_ofs <= 8'h00;
            byte_count <= 9'h000; buf_wp <= 1'b0; buf_rp <= 1'b0; buf_cnt <= 2'h0;
            clear_write_enable_o <= 1'b0; op_start_o <= 1'b0; op_kind_o <= 3'h0;
            op_addr_o <= 24'h000000; op_done_o <= 1'b0;
            buf_mem[0] <= 32'h00000000; buf_mem[1] <= 32'h00000000;
        end
        else
        begin
            clear_write_enable_o <= 1'b0;
            op_start_o <= 1'b0;
            op_done_o <= 1'b0;
            // buffer drain side
            if (wr_valid_o && wr_ready_i)
                buf_rp <= ~buf_rp;
            case (state)
            ST_IDLE:
            begin
                if (!cs_n_i && shift_i && !rejected)
                begin
                    byte_taken <= 1'b0;
                    // four-line mode shifts nibbles throughout; quad program switches after its opcode
                    if (four_line_command_mode_i || (quad && bitcnt >= `FPE_OPCODE_BITS))
                    begin
                        shreg <= {shreg[3:0], nib};
                        bitcnt <= bitcnt + 8'h04;
                    end
                    else
                    begin
                        shreg <= {shreg[6:0], serial_data_in_i};
                        bitcnt <= bitcnt + 8'h01;
                    end
                end
                // byte boundary reached this cycle
                if (!cs_n_i && !rejected && bitcnt[2:0] == 3'h0 && bitcnt != 8'h00 && !shift_i)
                begin
                    if (bitcnt == `FPE_OPCODE_BITS && opcode == 8'h00)
                    begin
                        opcode <= shreg;
                        quad <= (shreg == `FPE_OP_QPROG);
                        // latch, quad enable and mode gating
                        if (!write_enable_latch_i)
                            rejected <= 1'b1;
                        if (shreg == `FPE_OP_QPROG && (!quad_enable_bit_i || four_line_command_mode_i))
                            rejected <= 1'b1;
                        if (shreg != `FPE_OP_PROG && shreg != `FPE_OP_QPROG && shreg != `FPE_OP_SECT_ERASE
                            && shreg != `FPE_OP_BLK32_ERASE && shreg != `FPE_OP_BLK64_ERASE)
                            rejected <= 1'b1;
                        bitcnt <= bitcnt + 8'h80; // mark consumed without moving the byte count
                    end
                end
                if (cs_n_i)
                begin
                    // end of frame: accept only on a whole byte after the address
                    if (!rejected && opcode != 8'h00 && bitcnt[2:0] == 3'h0
                        && bitcnt >= `FPE_ADDR_END_BITS + 8'h80
                        && (!is_prog || byte_count != 9'h000))
                    begin
                        if (!prot_hit(addr, {protect_range_bit2_i, protect_range_bit1_i, protect_range_bit0_i},
                            protect_granularity_bit_i, protect_top_bottom_bit_i, protect_complement_bit_i))
                        begin
                            state <= ST_BUSY;
                            op_start_o <= 1'b1;
                            op_addr_o <= addr;
                            case (opcode)
                            `FPE_OP_SECT_ERASE:
                            begin
                                op_kind_o <= `FPE_KIND_SECT;
                                op_addr_o <= {addr[23:12], 12'h000};
                                timer <= SECT_CYCLES;
                            end
                            `FPE_OP_BLK32_ERASE:
                            begin
                                op_kind_o <= `FPE_KIND_BLK32;
                                op_addr_o <= {addr[23:15], 15'h0000};
                                timer <= BLK32_CYCLES;
                            end
                            `FPE_OP_BLK64_ERASE:
                            begin
                                op_kind_o <= `FPE_KIND_BLK64;
                                op_addr_o <= {addr[23:16], 16'h0000};
                                timer <= BLK64_CYCLES;
                            end
                            default:
                            begin
                                op_kind_o <= `FPE_KIND_PROG;
                                timer <= PROG_CYCLES;
                            end
                            endcase
                        end
                    end
                    opcode <= 8'h00; bitcnt <= 8'h00; rejected <= 1'b0; quad <= 1'b0; byte_taken <= 1'b0;
                    byte_count <= 9'h000;
                end
            end
            ST_BUSY:
            begin
                // new frames ignored while the cycle runs
                if (timer == 32'h00000001)
                    state <= ST_HOLD;
                timer <= timer - 32'h00000001;
            end
            ST_HOLD:
            begin
                // wait until buffered bytes reach the array before ending
                if (buf_cnt == 2'h0 || (buf_cnt == 2'h1 && wr_ready_i))
                begin
                    state <= ST_IDLE;
                    clear_write_enable_o <= 1'b1;
                    op_done_o <= 1'b1;
                end
            end
            default:
                state <= ST_IDLE;
            endcase
            // address capture and data byte handling on whole bytes
            if (take_byte)
            begin
                byte_taken <= 1'b1; // a byte counts once, the count stays on the boundary
                if (bitcnt <= `FPE_ADDR_END_BITS + 8'h80)
                begin
                    addr <= {addr[15:0], shreg};
                    page_ofs <= shreg;
                end
                else
                begin
                    if (is_prog)
                    begin
                        // data byte into the buffer; the low byte wraps inside the page
                        buf_mem[buf_wp] <= {addr[23:8], page_ofs, shreg};
                        buf_wp <= ~buf_wp;
                        page_ofs <= page_ofs + 8'h01;
                        if (byte_count != 9'h100)
                            byte_count <= byte_count + 9'h001;
                    end
                    // fold back to the address end so long bursts never overflow the count
                    bitcnt <= `FPE_ADDR_END_BITS + 8'h80;
                end
            end
            // occupancy follows both sides
            case ({take_byte && bitcnt > `FPE_ADDR_END_BITS + 8'h80 && is_prog,
                   wr_valid_o && wr_ready_i})
            2'b10:   buf_cnt <= buf_cnt + 2'h1;
            2'b01:   buf_cnt <= buf_cnt - 2'h1;
            default: buf_cnt <= buf_cnt;
            endcase
        end
    end

endmodule // fpe_sequencer
`default_nettype wire

// File: fpe_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpe_map.vh"
module fpe_sequencer_sva #(
    parameter PROG_CYCLES  = 8,
    parameter SECT_CYCLES  = 8,
    parameter BLK32_CYCLES = 8,
    parameter BLK64_CYCLES = 8
) (
    // clock, reset and inputs
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        cs_n_i,
    input wire logic        write_enable_latch_i,
    input wire logic        wr_ready_i,
    // observed outputs
    input wire logic        busy_o,
    input wire logic        clear_write_enable_o,
    input wire logic        wr_valid_o,
    input wire logic [23:0] wr_addr_o,
    input wire logic [7:0]  wr_data_o,
    input wire logic        op_start_o,
    input wire logic [2:0]  op_kind_o,
    input wire logic [23:0] op_addr_o,
    input wire logic        op_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // a start only ever follows the chip select rise of the cycle before
    a_start_on_cs: assert property (op_start_o |-> $past(cs_n_i) && !$past(cs_n_i, 2))
        else $error("start without chip select rise");
    a_start_needs_wel: assert property (op_start_o |-> $past(write_enable_latch_i))
        else $error("start with write enable latch clear");
    a_busy_holds: assert property (op_start_o |-> busy_o [*8])
        else $error("busy dropped early");
    a_busy_ends: assert property (op_start_o |-> ##[8:700] !busy_o)
        else $error("busy never ended");
    a_idle_start: assert property (op_start_o |-> !$past(busy_o))
        else $error("start accepted while busy");
    a_done_clears: assert property (op_done_o |-> clear_write_enable_o)
        else $error("latch not cleared at cycle end");
    a_done_in_busy: assert property (op_done_o |-> $past(busy_o))
        else $error("done outside a busy cycle");
    // a stalled word must not change, or the array loses data
    a_wr_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_addr_o, wr_data_o}))
        else $error("stalled word changed");
    a_erase_align: assert property (op_start_o |-> (op_kind_o != `FPE_KIND_SECT || op_addr_o[11:0] == 12'h000)
        && (op_kind_o != `FPE_KIND_BLK32 || op_addr_o[14:0] == 15'h0000)
        && (op_kind_o != `FPE_KIND_BLK64 || op_addr_o[15:0] == 16'h0000))
        else $error("erase address not aligned");
endmodule // fpe_sequencer_sva
bind fpe_sequencer fpe_sequencer_sva #(.PROG_CYCLES(PROG_CYCLES), .SECT_CYCLES(SECT_CYCLES),
    .BLK32_CYCLES(BLK32_CYCLES), .BLK64_CYCLES(BLK64_CYCLES)) u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cs_n_i(cs_n_i), .write_enable_latch_i(write_enable_latch_i), .wr_ready_i(wr_ready_i), .busy_o(busy_o),
    .clear_write_enable_o(clear_write_enable_o), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
    .op_done_o(op_done_o));
`default_nettype wire

// File: fpe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpe_host_model (
    // clock and buffer state
    input wire logic       clk_i,
    input wire logic       wr_valid_i,
    // serial link
    output var logic       cs_n_o,
    output var logic       shift_o,
    output var logic       sdi_o,
    output var logic [3:0] quad_o
);
    initial
    begin
        cs_n_o = 1'b1;
        shift_o = 1'b0;
        sdi_o = 1'b1;
        quad_o = 4'hF;
    end
    // one byte msb first, then the boundary gap; idle lines toggle so stale data never looks valid
    task put_byte(input logic [7:0] b, input logic quad, input logic data);
        int i;
        for (i = 0; data && wr_valid_i && i < 300; i++) @(posedge clk_i);
        for (i = 0; i < (quad ? 2 : 8); i++)
        begin
            @(posedge clk_i);
            shift_o <= 1'b1;
            sdi_o <= b[7 - i];
            quad_o <= i[0] ? b[3:0] : b[7:4];
        end
        @(posedge clk_i);
        shift_o <= 1'b0;
        sdi_o <= ~sdi_o;
        quad_o <= ~quad_o;
    endtask
    // whole frame: opcode, address msb first, data, optional stray bit
    task frame(input logic [7:0] op, input logic [23:0] a, input int n, input logic [7:0] d0,
               input logic qo, input logic qa, input logic extra);
        int j;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        put_byte(op, qo, 1'b0);
        for (j = 2; j >= 0; j--) put_byte(a[8 * j +: 8], qa, 1'b0);
        for (j = 0; j < n; j++) put_byte(d0 + j[7:0], qa, 1'b1);
        if (extra)
        begin
            @(posedge clk_i);
            shift_o <= 1'b1;
        end
        @(posedge clk_i);
        shift_o <= 1'b0;
        cs_n_o <= 1'b1;
    endtask
endmodule // fpe_host_model
`default_nettype wire

// File: fpe_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpe_map.vh"
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; $display("unexpected at %0t: %h %h", $time, g, e); end end
module fpe_sequencer_test;
    logic        clk, arst_n, four_line, qe, write_enable_latch, cmp, sec, tbot, status_read, wr_ready;
    logic        cs_n, shift, sdi, busy, clr_wel, wr_valid, op_start, op_done;
    logic [2:0]  bp, op_kind, last_kind;
    logic [3:0]  quad;
    logic [15:0] status;
    logic [23:0] wr_addr, op_addr, last_addr;
    logic [7:0]  wr_data;
    logic [7:0]  ops [4] = '{`FPE_OP_PROG, `FPE_OP_SECT_ERASE, `FPE_OP_BLK32_ERASE, `FPE_OP_BLK64_ERASE};
    logic [31:0] wq [$];
    int          seed = 23;
    int          miscompares = 0;
    int          compares = 0;
    int          starts = 0;
    int          clears = 0;
    int          k;
    // long large-block time so a second frame lands inside the busy cycle
    fpe_sequencer #(.PROG_CYCLES(8), .SECT_CYCLES(8), .BLK32_CYCLES(8), .BLK64_CYCLES(200)) u_dut (
        .clk_i(clk), .arst_n_i(arst_n), .cs_n_i(cs_n), .shift_i(shift), .serial_data_in_i(sdi),
        .quad_line0_i(quad[0]), .quad_line1_i(quad[1]), .quad_line2_i(quad[2]), .quad_line3_i(quad[3]),
        .four_line_command_mode_i(four_line), .quad_enable_bit_i(qe), .write_enable_latch_i(write_enable_latch),
        .protect_complement_bit_i(cmp), .protect_granularity_bit_i(sec), .protect_top_bottom_bit_i(tbot),
        .protect_range_bit2_i(bp[2]), .protect_range_bit1_i(bp[1]), .protect_range_bit0_i(bp[0]),
        .status_read_i(status_read), .busy_o(busy), .clear_write_enable_o(clr_wel), .status_data_o(status),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr), .op_done_o(op_done));
    fpe_host_model u_host (.clk_i(clk), .wr_valid_i(wr_valid), .cs_n_o(cs_n), .shift_o(shift), .sdi_o(sdi),
        .quad_o(quad));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // array side stalls at random and logs what it takes and what starts
    always @(posedge clk)
    begin
        wr_ready <= 1'($random(seed));
        if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
        if (op_start) starts++;
        if (op_start) last_kind <= op_kind;
        if (op_start) last_addr <= op_addr;
        clears += int'(clr_wel);
    end
    function automatic logic [2:0] kind_of(input logic [7:0] op);
        case (op)
            `FPE_OP_SECT_ERASE:  return `FPE_KIND_SECT;
            `FPE_OP_BLK32_ERASE: return `FPE_KIND_BLK32;
            `FPE_OP_BLK64_ERASE: return `FPE_KIND_BLK64;
            default:             return `FPE_KIND_PROG;
        endcase
    endfunction
    // one frame, a status read in the busy window, then the outcome
    task run(input logic [7:0] op, input int n, input logic qo, input logic qa, input logic extra,
             input logic ok, input logic busy2);
        int s0, c0, i;
        logic [23:0] a;
        logic [7:0] d0;
        s0 = starts;
        c0 = clears;
        a = {16'($random(seed)), 8'hF8};
        d0 = 8'($random(seed));
        wq.delete();
        u_host.frame(op, a, n, d0, qo, qa, extra);
        @(posedge clk);
        status_read <= 1'b1;
        @(posedge clk);
        status_read <= 1'b0;
        @(posedge clk);
        `CHECK(status[0], ok)
        `CHECK({status[9], status[1]}, {qe, write_enable_latch})
        if (busy2) u_host.frame(`FPE_OP_SECT_ERASE, a, 0, d0, qo, qa, 1'b0);
        for (i = 0; i < 800 && busy !== 1'b0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        `CHECK(starts - s0, int'(ok))
        `CHECK(clears - c0, int'(ok))
        if (ok && kind_of(op) != `FPE_KIND_PROG) `CHECK(last_kind, kind_of(op))
        if (ok && kind_of(op) != `FPE_KIND_PROG) `CHECK(last_addr[15:0] & 16'h0FFF, 16'h0000)
        if (ok && kind_of(op) == `FPE_KIND_PROG) `CHECK(wq.size(), n)
        for (i = 0; ok && kind_of(op) == `FPE_KIND_PROG && i < wq.size(); i++)
            `CHECK(wq[i], {a[23:8], a[7:0] + i[7:0], d0 + i[7:0]})
        $display("test of opcode %h done", op);
    endtask
    task end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {arst_n, four_line, qe, cmp, status_read, bp} = 8'h00;
        {write_enable_latch, sec, tbot} = 3'h4;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        {sec, tbot} <= 2'($random(seed));
        run(`FPE_OP_PROG, 12, 0, 0, 0, 1, 0);
        run(`FPE_OP_PROG, 258, 0, 0, 0, 1, 0);
        write_enable_latch <= 1'b0;
        run(`FPE_OP_PROG, 2, 0, 0, 0, 0, 0);
        run(`FPE_OP_SECT_ERASE, 0, 0, 0, 0, 0, 0);
        write_enable_latch <= 1'b1;
        run(`FPE_OP_SECT_ERASE, 0, 0, 0, 1, 0, 0);
        run(`FPE_OP_QPROG, 4, 0, 1, 0, 0, 0);
        qe <= 1'b1;
        run(`FPE_OP_QPROG, 4, 0, 1, 0, 1, 0);
        four_line <= 1'b1;
        run(`FPE_OP_QPROG, 4, 1, 1, 0, 0, 0);
        for (k = 0; k < 8; k++)
        begin
            four_line <= k[2];
            run(ops[k[1:0]], (k[1:0] == 2'h0) ? 3 : 0, k[2], k[2], 0, 1, 0);
        end
        bp <= 3'h7;
        run(`FPE_OP_BLK64_ERASE, 0, 1, 1, 0, 0, 0);
        bp <= 3'h0;
        run(`FPE_OP_BLK64_ERASE, 0, 1, 1, 0, 1, 1);
        end_sim;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        end_sim;
    end
endmodule // fpe_sequencer_test
`default_nettype wire
